// ==== ibp_pkg.sv ====
// Purpose: Shared constants and carriers of the two-wire bus engine
// Assumes: 8-bit registers on a plain strobe port
// Notes: Offsets are register indices
package ibp_pkg;
    localparam int REG_AW = 3;
    localparam int REG_DW = 8;
    // ************************************************
    // Register map
    // ************************************************
    localparam logic [2:0] OFF_OWN = 3'h0;
    localparam logic [2:0] OFF_DIV = 3'h1;
    localparam logic [2:0] OFF_CTRL = 3'h2;
    localparam logic [2:0] OFF_STAT = 3'h3;
    localparam logic [2:0] OFF_DATA = 3'h4;
    localparam logic [2:0] OFF_CTL2 = 3'h5;
    // ************************************************
    // Field positions
    // ************************************************
    localparam int CB_EN = 7;
    localparam int CB_MS = 5;
    localparam int CB_TX = 4;
    localparam int CB_TXAK = 3;
    localparam int CB_RSTA = 2;
    localparam int SB_TCF = 7;
    localparam int SB_AAS = 6;
    localparam int SB_BUSY = 5;
    localparam int SB_AL = 4;
    localparam int SB_SRW = 2;
    localparam int SB_RXAK = 0;
    localparam int C2_BROADCAST_CALL_ENABLE = 7;
    localparam int C2_LEN = 6;
    localparam int C2_HI = 2;
    localparam int OWN_LSB = 1;
    // ************************************************
    // Reset values and bus constants
    // ************************************************
    localparam logic [7:0] RST_DIV = 8'h10;
    localparam logic [7:0] ZERO_BYTE = 8'h00;
    localparam logic [7:0] GC_ADDR = 8'h00;
    localparam logic [4:0] TEN_MARK = 5'h1e;
    localparam logic [3:0] BIT_ZERO = 4'h0;
    localparam logic [3:0] BIT_LAST = 4'h7;
    localparam logic [3:0] BIT_ACK = 4'h8;
    localparam logic [3:0] BIT_DONE = 4'h9;
    localparam logic [3:0] BIT_ONE = 4'h1;

    typedef enum logic [2:0] {
        M_IDLE = 3'b000,
        M_START = 3'b001,
        M_WAIT = 3'b010,
        M_LOW = 3'b011,
        M_HIGH = 3'b100,
        M_STOP1 = 3'b101,
        M_STOP2 = 3'b110,
        M_RSTA = 3'b111
    } ibp_mstate_e;

    typedef struct packed {
        logic scl;
        logic sda;
        logic sclRise;
        logic sclFall;
        logic sdaRise;
        logic sdaFall;
    } ibp_line_s;
endpackage : ibp_pkg

// ==== ibp_line_sync.sv ====
// Purpose: Two-flop synchroniser and edge finder for both bus lines
// Assumes: Lines are asynchronous to mclk
// Notes: Edges come from the second and third stages only
`timescale 1ns/1ps
`default_nettype none
module ibp_line_sync
    import ibp_pkg::*;
(
    input wire logic mclk,
    input wire logic rstn,
    input wire logic sclIn,
    input wire logic sdaIn,
    output var ibp_line_s line
);
    typedef struct packed {
        logic [1:0] s1;
        logic [1:0] s2;
        logic [1:0] s3;
    } ibp_sync_s;

    ibp_sync_s r;
    ibp_sync_s next_r;

    always_comb begin
        next_r.s1 = {sclIn, sdaIn};
        next_r.s2 = r.s1;
        next_r.s3 = r.s2;
    end

    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            r <= '1;
        end else begin
            r <= next_r;
        end
    end

    always_comb begin
        line.scl = r.s2[1];
        line.sda = r.s2[0];
        line.sclRise = r.s2[1] & ~r.s3[1];
        line.sclFall = ~r.s2[1] & r.s3[1];
        line.sdaRise = r.s2[0] & ~r.s3[0];
        line.sdaFall = ~r.s2[0] & r.s3[0];
    end
endmodule : ibp_line_sync
`default_nettype wire

// ==== ibp_bus_engine.sv ====
// Purpose: Two-wire bus master/slave engine with its register file
// Assumes: Open-drain pins resolved outside; 100 MHz mclk
// Notes: Low half-period is the divider register plus one, high half the divider plus three, in mclk cycles
`timescale 1ns/1ps
`default_nettype none
// Behaviour
// - Control-two bit 7 enables answering and receiving the general call.
// - Control-two bit 6 selects seven-bit or ten-bit own address.
// - Control-two bits 5 to 3 always read as zero.
// - Control-two bits 2 to 0 are top bits of ten-bit address.
// - Control-two register is readable and writable at any time.
// - Lines are only pulled low or released, never driven high.
// - Master starts only on a free bus, data falling while clock high.
// - First byte holds seven address bits and a direction bit.
// - Ten-bit calling sends a second address byte right after the first.
// - Only a matching slave acknowledges, pulling data low on clock nine.
// - After losing arbitration in address, act as slave and answer properly.
// - Bytes are eight bits, MSB first, data changes while clock low.
// - Non-acknowledging slave receiver leaves data high; master stops or restarts.
// - Master receiver not acknowledging makes slave transmitter release data.
// - Stop is data rising while clock high; it frees the bus.
// - Repeated start begins a new calling without a stop.
// - A stop after an acknowledge makes the slave release the bus.
// - Driving one but reading zero loses arbitration: release, slave, flag.
// - Hold own low period, wait for real high, then count high.
// - Slave may stretch clock low; master waits for its release.
module ibp_bus_engine
    import ibp_pkg::*;
#(
    parameter int DIV_W = 8
) (
    input wire logic mclk,
    input wire logic rstn,
    input wire logic [REG_AW-1:0] regAddr,
    input wire logic [REG_DW-1:0] regWdata,
    input wire logic regWr,
    input wire logic regRd,
    output logic [REG_DW-1:0] regRdata,
    input wire logic sclIn,
    input wire logic sdaIn,
    output logic sclOut,
    output logic sclOe,
    output logic sdaOut,
    output logic sdaOe
);
    if (DIV_W < 4 || DIV_W > REG_DW) begin : g_chk
        $error("DIV_W must lie in 4..8");
    end

    typedef struct packed {
        logic [6:0] own;
        logic [DIV_W-1:0] div;
        logic en;
        logic ctlMaster;
        logic ctlTx;
        logic ctlTxak;
        logic rstaReq;
        logic goReq;
        logic broadcast_call_enable;
        logic lenSel;
        logic [2:0] ownHigh;
        logic tcf;
        logic addressed;
        logic busy;
        logic arbLost;
        logic srw;
        logic rxak;
        logic gcall;
        logic hiHit;
        logic addrPh;
        logic addr2Ph;
        logic ackNow;
        logic [7:0] shift;
        logic [7:0] rxData;
        logic [3:0] bitCnt;
        ibp_mstate_e ms;
        logic [DIV_W-1:0] cnt;
        logic sclHold;
        logic mSclLow;
        logic sdaDrive;
        logic sclOe;
        logic [7:0] rdata;
    } ibp_state_s;

    ibp_state_s r;
    ibp_state_s n;
    ibp_line_s ln;
    logic [7:0] byteIn;
    logic roleTx;
    logic ownBit;

    // ************************************************
    // Line synchroniser
    // ************************************************
    ibp_line_sync u_sync (
        .mclk(mclk),
        .rstn(rstn),
        .sclIn(sclIn),
        .sdaIn(sdaIn),
        .line(ln)
    );

    // Losing master releases data and falls back to slave
    function automatic ibp_state_s loseArb(input ibp_state_s s);
        ibp_state_s t;
        t = s;
        t.arbLost = 1'b1;
        t.ctlMaster = 1'b0;
        t.ms = M_IDLE;
        t.mSclLow = 1'b0;
        t.sdaDrive = 1'b0;
        t.goReq = 1'b0;
        t.rstaReq = 1'b0;
        return t;
    endfunction : loseArb

    function automatic logic [7:0] readValue(input ibp_state_s s,
                                             input logic [2:0] a);
        logic [7:0] v;
        v = ZERO_BYTE;
        unique case (a)
            OFF_OWN: v[7:OWN_LSB] = s.own;
            OFF_DIV: v[DIV_W-1:0] = s.div;
            OFF_CTRL: begin
                v[CB_EN] = s.en;
                v[CB_MS] = s.ctlMaster;
                v[CB_TX] = s.ctlTx;
                v[CB_TXAK] = s.ctlTxak;
            end
            OFF_STAT: begin
                v[SB_TCF] = s.tcf;
                v[SB_AAS] = s.addressed;
                v[SB_BUSY] = s.busy;
                v[SB_AL] = s.arbLost;
                v[SB_SRW] = s.srw;
                v[SB_RXAK] = s.rxak;
            end
            OFF_DATA: v = s.rxData;
            OFF_CTL2: begin
                v[C2_BROADCAST_CALL_ENABLE] = s.broadcast_call_enable;
                v[C2_LEN] = s.lenSel;
                v[C2_HI:0] = s.ownHigh;
            end
            default: v = ZERO_BYTE;
        endcase
        return v;
    endfunction : readValue

    // ************************************************
    // Next-state logic
    // ************************************************
    always_comb begin
        n = r;
        byteIn = {r.shift[6:0], ln.sda};
        roleTx = r.ctlTx && (r.ctlMaster || r.addressed);
        ownBit = r.ctlMaster && (r.ctlTx ? (r.bitCnt <= BIT_LAST)
                                         : (r.bitCnt == BIT_ACK));
        n.rdata = regRd ? readValue(r, regAddr) : ZERO_BYTE;
        if (regRd && regAddr == OFF_DATA) begin
            n.tcf = 1'b0;
            n.sclHold = 1'b0;
            if (r.ctlMaster && !r.ctlTx) begin
                n.goReq = 1'b1;
            end
        end
        if (regWr) begin
            unique case (regAddr)
                OFF_OWN: n.own = regWdata[7:OWN_LSB];
                OFF_DIV: n.div = regWdata[DIV_W-1:0];
                OFF_CTRL: begin
                    n.en = regWdata[CB_EN];
                    n.ctlTx = regWdata[CB_TX];
                    n.ctlTxak = regWdata[CB_TXAK];
                    if (regWdata[CB_MS] && !r.ctlMaster) begin
                        if (r.busy || !regWdata[CB_EN]) begin
                            n.arbLost = 1'b1;
                        end else begin
                            n.ctlMaster = 1'b1;
                            n.ms = M_START;
                            n.cnt = '0;
                        end
                    end else if (!regWdata[CB_MS]) begin
                        n.ctlMaster = 1'b0;
                    end
                    if (regWdata[CB_RSTA] && r.ctlMaster) begin
                        n.rstaReq = 1'b1;
                    end
                end
                OFF_STAT: begin
                    if (regWdata[SB_AL]) begin
                        n.arbLost = 1'b0;
                    end
                end
                OFF_DATA: begin
                    n.shift = regWdata;
                    n.tcf = 1'b0;
                    n.sclHold = 1'b0;
                    if (r.ctlMaster) begin
                        n.goReq = r.ctlTx;
                    end else if (roleTx && r.bitCnt == BIT_ZERO) begin
                        n.sdaDrive = ~regWdata[7];
                    end
                end
                OFF_CTL2: begin
                    n.broadcast_call_enable = regWdata[C2_BROADCAST_CALL_ENABLE];
                    n.lenSel = regWdata[C2_LEN];
                    n.ownHigh = regWdata[C2_HI:0];
                end
                default: n.en = r.en;
            endcase
        end

        // ************************************************
        // Bus events
        // ************************************************
        if (ln.sdaFall && ln.scl) begin
            n.busy = 1'b1;
            n.bitCnt = BIT_ZERO;
            n.addrPh = 1'b1;
            n.addr2Ph = 1'b0;
            n.addressed = 1'b0;
            n.gcall = 1'b0;
            n.sclHold = 1'b0;
        end else if (ln.sdaRise && ln.scl) begin
            n.busy = 1'b0;
            n.bitCnt = BIT_ZERO;
            n.addressed = 1'b0;
            n.sclHold = 1'b0;
            n.hiHit = 1'b0;
            n.addrPh = 1'b0;
            n.addr2Ph = 1'b0;
            if (r.ctlMaster) begin
                n = loseArb(n);
            end
        end else if (ln.sclRise && r.busy) begin
            n.shift = byteIn;
            n.bitCnt = r.bitCnt + BIT_ONE;
            if (ownBit && !r.sdaDrive && !ln.sda) begin
                n = loseArb(n);
            end
            if (r.bitCnt == BIT_LAST) begin
                n.ackNow = 1'b0;
                if (!roleTx) begin
                    n.rxData = byteIn;
                end
                if (r.addrPh && !n.ctlMaster) begin
                    n.addrPh = 1'b0;
                    if (byteIn == GC_ADDR && r.broadcast_call_enable) begin
                        n.gcall = 1'b1;
                        n.addressed = 1'b1;
                        n.srw = 1'b0;
                        n.ackNow = 1'b1;
                    end else if (!r.lenSel) begin
                        if (byteIn[7:1] == r.own) begin
                            n.addressed = 1'b1;
                            n.srw = byteIn[0];
                            n.ackNow = 1'b1;
                        end
                    end else if (byteIn[7:3] == TEN_MARK &&
                                 byteIn[2:1] == r.ownHigh[2:1]) begin
                        if (!byteIn[0]) begin
                            n.hiHit = 1'b1;
                            n.addr2Ph = 1'b1;
                            n.ackNow = 1'b1;
                        end else if (r.hiHit) begin
                            n.addressed = 1'b1;
                            n.srw = 1'b1;
                            n.ackNow = 1'b1;
                        end
                    end
                end else if (r.addr2Ph && !n.ctlMaster) begin
                    n.addr2Ph = 1'b0;
                    if (byteIn == {r.ownHigh[0], r.own}) begin
                        n.addressed = 1'b1;
                        n.srw = 1'b0;
                        n.ackNow = 1'b1;
                    end else begin
                        n.hiHit = 1'b0;
                    end
                end else begin
                    n.addrPh = 1'b0;
                    n.addr2Ph = 1'b0;
                    if (!roleTx && !r.ctlTxak) begin
                        n.ackNow = n.ctlMaster ||
                                   (r.addressed && (!r.gcall || r.broadcast_call_enable));
                    end
                end
            end
            if (r.bitCnt == BIT_ACK && roleTx) begin
                n.rxak = ln.sda;
                if (ln.sda && !r.ctlMaster) begin
                    n.addressed = 1'b0;
                end
            end
        end else if (ln.sclFall && r.busy) begin
            if (r.bitCnt == BIT_DONE) begin
                n.bitCnt = BIT_ZERO;
                n.sdaDrive = 1'b0;
                n.ackNow = 1'b0;
                n.tcf = r.ctlMaster || r.addressed;
                n.sclHold = r.addressed && !r.ctlMaster;
            end else if (r.bitCnt == BIT_ACK) begin
                n.sdaDrive = r.ackNow;
            end else if (r.bitCnt != BIT_ZERO) begin
                n.sdaDrive = roleTx && !r.shift[7];
            end
        end

        // ************************************************
        // Master clock generator
        // ************************************************
        unique case (r.ms)
            M_IDLE: n.mSclLow = 1'b0;
            M_START: begin
                n.sdaDrive = 1'b1;
                n.cnt = r.cnt + 1'b1;
                if (r.cnt == r.div) begin
                    n.cnt = '0;
                    n.mSclLow = 1'b1;
                    n.ms = M_WAIT;
                end
            end
            M_WAIT: begin
                n.mSclLow = 1'b1;
                n.cnt = '0;
                if (!r.ctlMaster) begin
                    n.ms = M_STOP1;
                end else if (r.rstaReq && r.bitCnt == BIT_ZERO) begin
                    n.rstaReq = 1'b0;
                    n.ms = M_RSTA;
                end else if (r.goReq && r.bitCnt == BIT_ZERO) begin
                    n.goReq = 1'b0;
                    n.ms = M_LOW;
                    if (r.ctlTx) begin
                        n.sdaDrive = ~r.shift[7];
                    end
                end
            end
            M_LOW: begin
                n.mSclLow = 1'b1;
                n.cnt = r.cnt + 1'b1;
                if (r.cnt == r.div) begin
                    n.cnt = '0;
                    n.mSclLow = 1'b0;
                    n.ms = M_HIGH;
                end
            end
            M_HIGH: begin
                n.mSclLow = 1'b0;
                if (ln.scl) begin
                    n.cnt = r.cnt + 1'b1;
                    if (r.cnt == r.div) begin
                        n.cnt = '0;
                        n.mSclLow = 1'b1;
                        n.ms = (r.bitCnt == BIT_DONE) ? M_WAIT : M_LOW;
                    end
                end else if (r.cnt != '0) begin
                    n.cnt = '0;
                    n.mSclLow = 1'b1;
                    n.ms = M_LOW;
                end
            end
            M_STOP1: begin
                n.sdaDrive = 1'b1;
                n.mSclLow = 1'b1;
                n.cnt = r.cnt + 1'b1;
                if (r.cnt == r.div) begin
                    n.cnt = '0;
                    n.mSclLow = 1'b0;
                    n.ms = M_STOP2;
                end
            end
            M_STOP2: begin
                n.sdaDrive = 1'b1;
                if (ln.scl) begin
                    n.cnt = r.cnt + 1'b1;
                    if (r.cnt == r.div) begin
                        n.cnt = '0;
                        n.sdaDrive = 1'b0;
                        n.ms = M_IDLE;
                    end
                end
            end
            M_RSTA: begin
                n.sdaDrive = 1'b0;
                n.mSclLow = r.cnt < r.div;
                n.cnt = r.cnt + 1'b1;
                if (r.cnt > r.div && !ln.scl) begin
                    n.cnt = r.cnt;
                end
                if (r.cnt == {DIV_W{1'b1}} || (ln.scl && r.cnt > r.div)) begin
                    n.cnt = '0;
                    n.ms = M_START;
                end
            end
        endcase

        if (!n.en) begin
            n.ctlMaster = 1'b0;
            n.ms = M_IDLE;
            n.mSclLow = 1'b0;
            n.sclHold = 1'b0;
            n.sdaDrive = 1'b0;
            n.addressed = 1'b0;
            n.goReq = 1'b0;
            n.rstaReq = 1'b0;
        end
        n.sclOe = n.mSclLow | n.sclHold;
    end

    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            r <= '0;
            r.div <= RST_DIV[DIV_W-1:0];
        end else begin
            r <= n;
        end
    end

    // ************************************************
    // Outputs
    // ************************************************
    assign regRdata = r.rdata;
    assign sclOe = r.sclOe;
    assign sdaOe = r.sdaDrive;
    assign sclOut = r.ackNow & 1'b0;
    assign sdaOut = r.ackNow & 1'b0;
endmodule : ibp_bus_engine
`default_nettype wire

// ==== ibp_bus_engine_chk.sv ====
// Purpose: Port assertions of the bus engine
// Assumes: Lines resolved with pull-ups
// Notes: Bound into every engine instance
`timescale 1ns/1ps
`default_nettype none
module ibp_bus_engine_chk
    import ibp_pkg::*;
#(
    parameter int DIV_W = 8
) (
    input wire logic mclk,
    input wire logic rstn,
    input wire logic [REG_AW-1:0] regAddr,
    input wire logic [REG_DW-1:0] regWdata,
    input wire logic regWr,
    input wire logic regRd,
    input wire logic [REG_DW-1:0] regRdata,
    input wire logic sclIn,
    input wire logic sdaIn,
    input wire logic sclOut,
    input wire logic sclOe,
    input wire logic sdaOut,
    input wire logic sdaOe
);
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!rstn);
    sequence ctl2Write;
        regWr && regAddr == OFF_CTL2;
    endsequence
    sequence ctl2Read;
        regRd && regAddr == OFF_CTL2;
    endsequence
    sequence startDrive;
        $rose(sdaOe) && sclIn;
    endsequence
    sequence slaveAck;
        $rose(sdaOe) && !sclIn && !sclOe;
    endsequence
    chk_pins_open_drain:
        assert property (!sclOut && !sdaOut)
        else $error("line driven high");
    chk_idle_read_zero:
        assert property (!regRd |=> regRdata == ZERO_BYTE)
        else $error("read data outside read slot");
    chk_ctl2_reserved:
        assert property (ctl2Read |=> regRdata[5:3] == 3'h0)
        else $error("reserved bits not zero");
    chk_ctl2_readback:
        assert property (ctl2Write ##1 !regWr ##1 ctl2Read |=>
            regRdata == ($past(regWdata, 3) & 8'hc7))
        else $error("control two readback wrong");
    chk_unmapped_zero:
        assert property (regRd && regAddr > OFF_CTL2 |=> regRdata == 8'h00)
        else $error("unmapped read not zero");
    chk_start_bus_free:
        assert property (startDrive |-> $past(sdaIn))
        else $error("start on busy data line");
    chk_start_then_clock:
        assert property (startDrive |-> ##[1:64] sclOe)
        else $error("no clock after start");
    chk_ack_stands:
        assert property (slaveAck |-> sdaOe [*4])
        else $error("ack too short");
    chk_high_counted:
        assert property ($rose(sclOe) && $past(sclIn) |-> $past(sclIn, 3))
        else $error("clock high not counted");
endmodule : ibp_bus_engine_chk
bind ibp_bus_engine ibp_bus_engine_chk #(.DIV_W(DIV_W)) u_chk (
    .mclk(mclk), .rstn(rstn), .regAddr(regAddr), .regWdata(regWdata),
    .regWr(regWr), .regRd(regRd), .regRdata(regRdata), .sclIn(sclIn),
    .sdaIn(sdaIn), .sclOut(sclOut), .sclOe(sclOe), .sdaOut(sdaOut),
    .sdaOe(sdaOe)
);
`default_nettype wire

// ==== ibp_peer_master.sv ====
// Purpose: Far-side bus master for the engine bench
// Assumes: Pulls only; bench resolves the lines
// Notes: Half bit is 8 mclk cycles, 190 ns clock
`timescale 1ns/1ps
`default_nettype none
module ibp_peer_master (
    input wire logic mclk,
    input wire logic scl,
    input wire logic sda,
    output logic sclPull,
    output logic sdaPull
);
    localparam int HALF = 8;
    initial begin
        sclPull = 1'b0;
        sdaPull = 1'b0;
    end
    task automatic half_bit();
        repeat (HALF) @(posedge mclk);
    endtask : half_bit
    // Waits out a slave stretching the clock
    task automatic wait_high();
        for (int k = 0; k < 4000 && !scl; k++) @(posedge mclk);
    endtask : wait_high
    task automatic start_cond();
        half_bit();
        sdaPull <= 1'b1;
        half_bit();
        sclPull <= 1'b1;
        half_bit();
    endtask : start_cond
    task automatic send_byte(input logic [7:0] b, output logic ack);
        logic [8:0] frame;
        frame = {b, 1'b1};
        for (int i = 0; i < 9; i++) begin
            repeat (2) @(posedge mclk);
            sdaPull <= !frame[8 - i];
            half_bit();
            sclPull <= 1'b0;
            @(posedge mclk);
            wait_high();
            half_bit();
            ack = !sda;
            sclPull <= 1'b1;
        end
        half_bit();
    endtask : send_byte
    task automatic stop_cond();
        sdaPull <= 1'b1;
        half_bit();
        sclPull <= 1'b0;
        @(posedge mclk);
        wait_high();
        half_bit();
        sdaPull <= 1'b0;
        half_bit();
    endtask : stop_cond
endmodule : ibp_peer_master
`default_nettype wire

// ==== testbench.sv ====
// Purpose: Self-checking bench of the bus engine
// Assumes: Peer master on the far side
// Notes: Rows cover slave addressing
`timescale 1ns/1ps
`default_nettype none
module testbench
    import ibp_pkg::*;
;
    typedef struct packed {
        logic [7:0] ctl2;
        logic [7:0] b1;
        logic [7:0] b2;
        logic two;
        logic ack;
    } ibp_row_s;
    localparam ibp_row_s ROWS [6] = '{
        '{8'h00, 8'h5a, 8'h00, 1'b0, 1'b1},
        '{8'h00, 8'h5c, 8'h00, 1'b0, 1'b0},
        '{8'hb8, 8'h00, 8'h3c, 1'b1, 1'b1},
        '{8'h00, 8'h00, 8'h00, 1'b0, 1'b0},
        '{8'h7d, 8'hf4, 8'had, 1'b1, 1'b1},
        '{8'h45, 8'hf4, 8'hac, 1'b1, 1'b0}};
    logic mclk = 1'b0, rstn = 1'b0, regWr = 1'b0, regRd = 1'b0;
    logic tbSda = 1'b0;
    logic [REG_AW-1:0] regAddr = '0;
    logic [REG_DW-1:0] regWdata = '0, regRdata, d;
    logic sclOut, sclOe, sdaOut, sdaOe, peerScl, peerSda, ack;
    logic [8:0] shift = '0;
    int checks = 0, mismatches = 0, cycles = 0;
    wire logic scl = ~(sclOe | peerScl);
    wire logic sda = ~(sdaOe | peerSda | tbSda);
    ibp_bus_engine #(.DIV_W(8)) u_dut (.mclk(mclk), .rstn(rstn),
        .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr),
        .regRd(regRd), .regRdata(regRdata), .sclIn(scl), .sdaIn(sda),
        .sclOut(sclOut), .sclOe(sclOe), .sdaOut(sdaOut), .sdaOe(sdaOe));
    ibp_peer_master u_peer (.mclk(mclk), .scl(scl), .sda(sda),
        .sclPull(peerScl), .sdaPull(peerSda));
    initial begin
        forever #5 mclk = ~mclk;
    end
    always @(posedge scl) shift <= {shift[7:0], sda};
    always @(posedge mclk) begin
        cycles <= cycles + 1;
        if (cycles == 60000) begin
            mismatches++;
            stop_test();
        end
    end
    // ************
    // Tasks
    // ************
    task automatic stop_test();
        $display("checks %0d mismatches %0d", checks, mismatches);
        if (mismatches == 0 && checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : stop_test
    task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
        checks++;
        if (got !== exp) begin
            mismatches++;
            $display("mismatch at %0t got %h exp %h", $time, got, exp);
        end
    endtask : chk8
    task automatic reg_wr(input logic [2:0] a, input logic [7:0] v);
        regAddr <= a;
        regWdata <= v;
        regWr <= 1'b1;
        @(posedge mclk);
        regWr <= 1'b0;
        // Idle edge so a following write never reassigns the strobe
        @(posedge mclk);
    endtask : reg_wr
    task automatic reg_rd(input logic [2:0] a, output logic [7:0] v);
        regAddr <= a;
        regRd <= 1'b1;
        @(posedge mclk);
        regRd <= 1'b0;
        #1 v = regRdata;
        @(posedge mclk);
    endtask : reg_rd
    task automatic wait_stat(input logic [7:0] m, input logic [7:0] v);
        for (int k = 0; k < 300; k++) begin
            reg_rd(OFF_STAT, d);
            if ((d & m) === v) break;
        end
        chk8(d & m, v);
    endtask : wait_stat
    task automatic do_reset();
        rstn <= 1'b0;
        repeat (20) @(posedge mclk);
        rstn <= 1'b1;
        @(posedge mclk);
    endtask : do_reset
    task automatic setup();
        reg_wr(OFF_DIV, 8'h03);
        reg_wr(OFF_OWN, 8'h5a);
        reg_wr(OFF_CTRL, 8'h80);
    endtask : setup
    // ************
    // Sequence
    // ************
    initial begin
        do_reset();
        setup();
        foreach (ROWS[i]) begin
            reg_wr(OFF_CTL2, ROWS[i].ctl2);
            reg_rd(OFF_CTL2, d);
            chk8(d, ROWS[i].ctl2 & 8'hc7);
            u_peer.start_cond();
            u_peer.send_byte(ROWS[i].b1, ack);
            reg_rd(OFF_DATA, d);
            if (ROWS[i].two) begin
                u_peer.send_byte(ROWS[i].b2, ack);
                reg_rd(OFF_DATA, d);
            end
            chk8({7'h0, ack}, {7'h0, ROWS[i].ack});
            u_peer.stop_cond();
            $display("row %0d done", i);
        end
        do_reset();
        reg_rd(OFF_CTL2, d);
        chk8(d, ZERO_BYTE);
        reg_rd(OFF_DIV, d);
        chk8(d, RST_DIV);
        reg_wr(3'h6, 8'hff);
        reg_rd(3'h6, d);
        chk8(d, ZERO_BYTE);
        $display("reset test done");
        setup();
        reg_wr(OFF_CTRL, 8'hb0);
        reg_wr(OFF_DATA, 8'ha6);
        wait_stat(8'h81, 8'h81);
        chk8(shift[8:1], 8'ha6);
        reg_wr(OFF_CTRL, 8'h90);
        wait_stat(8'h20, 8'h00);
        $display("master write done");
        reg_wr(OFF_CTRL, 8'hb0);
        reg_wr(OFF_DATA, 8'h80);
        for (int k = 0; k < 200 && scl; k++) @(posedge mclk);
        tbSda <= 1'b1;
        wait_stat(8'h10, 8'h10);
        reg_rd(OFF_CTRL, d);
        chk8(d & 8'h20, 8'h00);
        chk8({7'h0, sdaOe}, 8'h00);
        tbSda <= 1'b0;
        reg_wr(OFF_STAT, 8'h10);
        wait_stat(8'h30, 8'h00);
        $display("arbitration done");
        u_peer.start_cond();
        reg_wr(OFF_CTRL, 8'hb0);
        wait_stat(8'h30, 8'h30);
        u_peer.stop_cond();
        $display("busy start done");
        stop_test();
    end
endmodule : testbench
`default_nettype wire
